// ### hdl/pssb_ctrl.sv
// Host controller: user commands pass a FIFO and drive the bus; read words return on rdata.
module pssb_fifo #(
   parameter int W = 8,
   parameter int D = pssb_pkg::FIFO_DEPTH
) (
   input  wire logic         clk_i,     // Clock.
   input  wire logic         nrst_i,    // Reset, active low.
   input  wire logic [W-1:0] in_data_i, // Word to store.
   input  wire logic         in_vld_i,  // Word offered.
   output logic              in_rdy_o,  // Room free.
   output logic [W-1:0]      out_data_o,// Oldest word.
   output logic              out_vld_o, // Not empty.
   input  wire logic         out_rdy_i  // Drain.
);
   localparam int PW = $clog2(D);
   logic [W-1:0]  mem_r [D];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PW:0]   n_r, n_nxt;
   logic          wr, rd;

   // Pointer update; full and empty come straight from the count.
   always_comb begin
      wr     = in_vld_i && (n_r != (PW+1)'(D));
      rd     = out_rdy_i && (n_r != '0);
      wp_nxt = wr ? PW'((wp_r + 1) % D) : wp_r;
      rp_nxt = rd ? PW'((rp_r + 1) % D) : rp_r;
      n_nxt  = (PW+1)'(n_r + (PW+1)'(wr) - (PW+1)'(rd));
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wp_r <= '0;
         rp_r <= '0;
         n_r  <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         n_r  <= n_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr) begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   assign in_rdy_o   = n_r != (PW+1)'(D);
   assign out_vld_o  = n_r != '0;
   assign out_data_o = mem_r[rp_r];
endmodule : pssb_fifo

module pssb_ctrl #(
   parameter int AW = pssb_pkg::ADDR_W,
   parameter int DW = pssb_pkg::DATA_W,
   parameter int NL = pssb_pkg::LANES
) (
   input  wire logic          clk_i,       // Clock.
   input  wire logic          nrst_i,      // Reset, active low.
   input  wire logic          cmd_vld_i,   // Command offered.
   output logic               cmd_rdy_o,   // FIFO has room.
   input  wire logic          cmd_rd_i,    // 1 read, 0 write.
   input  wire logic          cmd_adv_i,   // Burst advance instead of load.
   input  wire logic [AW-1:0] cmd_addr_i,  // Load address.
   input  wire logic [NL-1:0] cmd_ben_n_i, // Byte lanes, active low.
   input  wire logic [DW-1:0] cmd_wdata_i, // Write word.
   input  wire logic          suspend_i,   // Hold the bus clock enable off.
   input  wire logic          interleave_i,// Burst order strap.
   output logic [DW-1:0]      rdata_o,     // Read word.
   output logic               rvalid_o,    // Read word strobe.
   pssb_if.ctl                bus          // Bus side.
);
   localparam int CW = 2 + AW + NL + DW;
   logic [CW-1:0] f_data;
   logic          f_vld, go;
   logic [3:0]    rdp_r, rdp_nxt;
   logic [2:0]    wrp_r, wrp_nxt;
   logic [DW-1:0] wd1_r, wd1_nxt, wd2_r, wd2_nxt, wd3_r, wd3_nxt;
   logic          susp_r, susp_nxt;

   pssb_fifo #(.W(CW), .D(pssb_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .in_data_i ({cmd_rd_i, cmd_adv_i, cmd_addr_i, cmd_ben_n_i, cmd_wdata_i}),
      .in_vld_i  (cmd_vld_i),
      .in_rdy_o  (cmd_rdy_o),
      .out_data_o(f_data),
      .out_vld_o (f_vld),
      .out_rdy_i (go)
   );

   // Issue one command per unsuspended cycle; empty FIFO issues a deselect.
   assign go = f_vld && !susp_r;

   // The memory takes a command one enabled edge after it leaves here, so write data goes out
   // three enabled edges after issue and a read word is taken at the fourth.
   always_comb begin
      susp_nxt = suspend_i;
      rdp_nxt  = rdp_r;
      wrp_nxt  = wrp_r;
      wd1_nxt  = wd1_r;
      wd2_nxt  = wd2_r;
      wd3_nxt  = wd3_r;
      if (!susp_r) begin
         rdp_nxt = {rdp_r[2:0], go && f_data[CW-1]};
         wrp_nxt = {wrp_r[1:0], go && !f_data[CW-1]};
         wd3_nxt = wd2_r;
         wd2_nxt = wd1_r;
         wd1_nxt = f_data[DW-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         susp_r                <= 1'b0;
         rdp_r                 <= 4'h0;
         wrp_r                 <= 3'h0;
         wd1_r                 <= '0;
         wd2_r                 <= '0;
         wd3_r                 <= '0;
         bus.addr              <= '0;
         bus.read_not_write    <= pssb_pkg::CMD_READ;
         bus.advance_not_load  <= 1'b0;
         bus.chip_select_a_n   <= pssb_pkg::RST_SEL_A_N;
         bus.chip_select_b     <= pssb_pkg::RST_SEL_B;
         bus.chip_select_c_n   <= 1'b1;
         bus.byte_lane_write_n <= '1;
         bus.clock_suspend_n   <= 1'b0;
         bus.linear_burst_order <= 1'b0;
         bus.ctl_dq_o          <= '0;
         bus.ctl_dq_oe_n       <= 1'b1;
         rdata_o               <= '0;
         rvalid_o              <= 1'b0;
      end else begin
         susp_r                <= susp_nxt;
         rdp_r                 <= rdp_nxt;
         wrp_r                 <= wrp_nxt;
         wd1_r                 <= wd1_nxt;
         wd2_r                 <= wd2_nxt;
         wd3_r                 <= wd3_nxt;
         bus.clock_suspend_n   <= susp_nxt;
         bus.linear_burst_order <= interleave_i;
         if (!susp_r) begin
            bus.addr              <= f_data[DW+NL +: AW];
            bus.read_not_write    <= f_data[CW-1];
            bus.advance_not_load  <= go && f_data[CW-2];
            bus.chip_select_a_n   <= !go;
            bus.chip_select_b     <= go;
            bus.chip_select_c_n   <= !go;
            bus.byte_lane_write_n <= f_data[DW +: NL];
            bus.ctl_dq_o          <= wd3_r;
            bus.ctl_dq_oe_n       <= !wrp_r[2];
            rvalid_o              <= rdp_r[3];
            rdata_o               <= bus.dq;
         end else begin
            rvalid_o <= 1'b0;
         end
      end
   end
endmodule : pssb_ctrl

// ### hdl/pssb_sram.sv
module pssb_sram #(
   parameter int AW = pssb_pkg::ADDR_W,
   parameter int DW = pssb_pkg::DATA_W,
   parameter int NL = pssb_pkg::LANES
) (
   input wire logic clk_i,      // Bus clock.
   input wire logic nrst_i,     // Asynchronous reset, active low.
   pssb_if.mem      bus         // Memory side of the bus.
);
   localparam int LW = DW / NL;

   typedef struct packed {
      logic          vld;
      logic          rd;
      logic [AW-1:0] addr;
      logic [NL-1:0] ben_n;
   } pssb_stage_type;

   logic [DW-1:0]  mem_r [2**AW];
   pssb_stage_type st1_r, st1_nxt, st2_r, st2_nxt, st3_r, st3_nxt;
   logic [AW-1:0]  base_r, base_nxt;
   logic [1:0]     cnt_r, cnt_nxt;
   logic           brd_r, brd_nxt;
   logic           bact_r, bact_nxt;
   logic [DW-1:0]  q_r, q_nxt;
   logic           qv_r, qv_nxt;
   logic           sel;

   // Burst address from start and step count.
   function automatic logic [AW-1:0] pssb_burst_addr(input logic [AW-1:0] b, input logic [1:0] c,
                                                     input logic il);
      logic [1:0] lo;
      lo = il ? (b[1:0] ^ c) : 2'(b[1:0] + c);
      return {b[AW-1:2], lo};
   endfunction : pssb_burst_addr

   assign sel = !bus.chip_select_a_n && bus.chip_select_b && !bus.chip_select_c_n;

   // Command decode and the three-stage pipeline; a suspended edge holds everything.
   always_comb begin
      st1_nxt  = st1_r;
      st2_nxt  = st2_r;
      st3_nxt  = st3_r;
      base_nxt = base_r;
      cnt_nxt  = cnt_r;
      brd_nxt  = brd_r;
      bact_nxt = bact_r;
      q_nxt    = q_r;
      qv_nxt   = qv_r;
      if (!bus.clock_suspend_n) begin
         st2_nxt = st1_r;
         st3_nxt = st2_r;
         st1_nxt = '0;
         if (!bus.advance_not_load) begin
            if (sel) begin
               base_nxt = bus.addr;
               cnt_nxt  = 2'h0;
               brd_nxt  = bus.read_not_write;
               bact_nxt = 1'b1;
               st1_nxt  = '{1'b1, bus.read_not_write, bus.addr, bus.byte_lane_write_n};
            end else begin
               bact_nxt = 1'b0;
            end
         end else if (bact_r) begin
            cnt_nxt = 2'(cnt_r + 2'h1);
            st1_nxt = '{1'b1, brd_r, pssb_burst_addr(base_r, 2'(cnt_r + 2'h1), bus.linear_burst_order),
                        bus.byte_lane_write_n};
         end
         // Data phase of the older stage.
         qv_nxt = st2_r.vld && st2_r.rd;
         if (st2_r.vld && st2_r.rd) begin
            q_nxt = mem_r[st2_r.addr];
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st1_r  <= '0;
         st2_r  <= '0;
         st3_r  <= '0;
         base_r <= '0;
         cnt_r  <= 2'h0;
         brd_r  <= 1'b0;
         bact_r <= 1'b0;
         q_r    <= '0;
         qv_r   <= 1'b0;
      end else begin
         st1_r  <= st1_nxt;
         st2_r  <= st2_nxt;
         st3_r  <= st3_nxt;
         base_r <= base_nxt;
         cnt_r  <= cnt_nxt;
         brd_r  <= brd_nxt;
         bact_r <= bact_nxt;
         q_r    <= q_nxt;
         qv_r   <= qv_nxt;
      end
   end

   // Write data is taken at the end of its data cycle, one stage behind the read word, so a read
   // followed by a write never has both ends on the wire at once. The array has no reset.
   always_ff @(posedge clk_i) begin
      if (bus.clock_suspend_n == 1'b0 && st3_r.vld && !st3_r.rd) begin
         for (int l = 0; l < NL; l++) begin
            if (!st3_r.ben_n[l]) begin
               mem_r[st3_r.addr][l*LW +: LW] <= bus.dq[l*LW +: LW];
            end
         end
      end
   end

   // Output enable acts without the clock, as the pin does.
   assign bus.mem_dq_o    = q_r;
   assign bus.mem_dq_oe_n = !(qv_r && !bus.output_drive_enable_n);
endmodule : pssb_sram

// ### inc/pssb_if.sv
interface pssb_if #(
   parameter int AW = pssb_pkg::ADDR_W,
   parameter int DW = pssb_pkg::DATA_W,
   parameter int NL = pssb_pkg::LANES
) (
   input wire logic clk_i
);
   logic [AW-1:0] addr;
   logic          read_not_write;
   logic          advance_not_load;
   logic          chip_select_a_n;
   logic          chip_select_b;
   logic          chip_select_c_n;
   logic          clock_suspend_n;
   logic [NL-1:0] byte_lane_write_n;
   logic          output_drive_enable_n;
   logic          linear_burst_order;
   logic [DW-1:0] mem_dq_o;
   logic          mem_dq_oe_n;
   logic [DW-1:0] ctl_dq_o;
   logic          ctl_dq_oe_n;
   logic [DW-1:0] dq;

   // Resolved data wire; enables are active low.
   assign dq = !mem_dq_oe_n ? mem_dq_o : (!ctl_dq_oe_n ? ctl_dq_o : '0);

   modport mem (input addr, read_not_write, advance_not_load, chip_select_a_n, chip_select_b,
                chip_select_c_n, clock_suspend_n, byte_lane_write_n, output_drive_enable_n,
                linear_burst_order, dq, output mem_dq_o, mem_dq_oe_n);
   modport ctl (output addr, read_not_write, advance_not_load, chip_select_a_n, chip_select_b,
                chip_select_c_n, clock_suspend_n, byte_lane_write_n, output_drive_enable_n,
                linear_burst_order, ctl_dq_o, ctl_dq_oe_n, input dq);
endinterface : pssb_if

// ### inc/pssb_pkg.sv
package pssb_pkg;
   // Bus geometry defaults; both ends take ADDR_W, DATA_W and LANES as parameter defaults.
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;
   localparam int LANES       = 4;
   localparam int BURST_LEN   = 4;
   localparam int LAT         = 2;
   localparam int FIFO_DEPTH  = 8;
   // Command encodings on the user side of the controller.
   localparam logic CMD_READ  = 1'b1;
   localparam logic CMD_WRITE = 1'b0;
   // Reset values of the driven bus controls.
   localparam logic RST_SEL_A_N = 1'b1;
   localparam logic RST_SEL_B   = 1'b0;
endpackage : pssb_pkg

// ### verif/pssb_properties.sv
module pssb_properties #(
   parameter int DW = pssb_pkg::DATA_W
) (
   input wire logic          clk_i,                 // Clock.
   input wire logic          nrst_i,                // Reset, low.
   input wire logic          read_not_write,        // Direction.
   input wire logic          advance_not_load,      // Advance.
   input wire logic          chip_select_a_n,       // Select a.
   input wire logic          chip_select_b,         // Select b.
   input wire logic          chip_select_c_n,       // Select c.
   input wire logic          clock_suspend_n,       // Suspend.
   input wire logic          output_drive_enable_n, // Output enable.
   input wire logic [DW-1:0] mem_dq_o,              // Memory data.
   input wire logic          mem_dq_oe_n,           // Memory drive.
   input wire logic          ctl_dq_oe_n            // Controller drive.
);
   timeunit 1ns;
   timeprecision 100ps;
   // Selection needs all three selects true; drv also passes when outputs are gated off.
   wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
   wire drv = output_drive_enable_n || !mem_dq_oe_n;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Loads, deselect, advance and two enabled edges, the steps of each pipeline slot.
   sequence s_rd; !clock_suspend_n && !advance_not_load && sel && read_not_write; endsequence
   sequence s_wr; !clock_suspend_n && !advance_not_load && sel && !read_not_write; endsequence
   sequence s_ds; !clock_suspend_n && !advance_not_load && !sel; endsequence
   sequence s_adv; !clock_suspend_n && advance_not_load; endsequence
   sequence s_en2; !clock_suspend_n [*2]; endsequence
   a_read_drive: assert property (s_rd ##1 s_en2 |=> drv)
      else $error("read word not driven");
   a_burst_drive: assert property (s_rd ##1 s_adv ##1 s_en2 |=> drv)
      else $error("burst word not driven");
   a_susp_latency: assert property (s_rd ##1 clock_suspend_n ##1 s_en2 |=> drv)
      else $error("suspended read lost");
   a_write_float: assert property (s_wr ##1 s_en2 |=> mem_dq_oe_n && !ctl_dq_oe_n)
      else $error("write slot bus wrong");
   a_desel_float: assert property (s_ds ##1 s_en2 |=> mem_dq_oe_n)
      else $error("bus not floated after deselect");
   a_noop_float: assert property (s_ds ##1 s_adv ##1 s_en2 |=> mem_dq_oe_n)
      else $error("noop drove the bus");
   a_oe_gate: assert property (output_drive_enable_n |-> mem_dq_oe_n)
      else $error("drive while output enable off");
   a_no_clash: assert property (mem_dq_oe_n || ctl_dq_oe_n)
      else $error("both ends drive data");
   a_susp_hold: assert property (clock_suspend_n ##1 $stable(output_drive_enable_n)
                                 |-> $stable(mem_dq_o) && $stable(mem_dq_oe_n))
      else $error("output moved on suspended edge");
endmodule : pssb_properties

// ### verif/test_pipelined_sync_sram_bus_ops.sv
module test_pipelined_sync_sram_bus_ops;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_i, nrst_i, vld, rd, adv, susp, ilv, oe_n, rvalid, rdy;
   logic [7:0]  addr;
   logic [3:0]  ben_n;
   logic [31:0] wd, rdata;
   logic [31:0] mem [256];
   logic [31:0] rq [$];
   int          err_total, check_count, cyc;

   pssb_if bus_if (.clk_i(clk_i));
   pssb_sram pssb_sram_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus_if));
   pssb_ctrl pssb_ctrl_i (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_vld_i(vld), .cmd_rdy_o(rdy), .cmd_rd_i(rd),
      .cmd_adv_i(adv), .cmd_addr_i(addr), .cmd_ben_n_i(ben_n), .cmd_wdata_i(wd), .suspend_i(susp),
      .interleave_i(ilv), .rdata_o(rdata), .rvalid_o(rvalid), .bus(bus_if));
   pssb_properties pssb_properties_i (.clk_i(clk_i), .nrst_i(nrst_i), .read_not_write(bus_if.read_not_write),
      .advance_not_load(bus_if.advance_not_load), .chip_select_a_n(bus_if.chip_select_a_n),
      .chip_select_b(bus_if.chip_select_b), .chip_select_c_n(bus_if.chip_select_c_n),
      .clock_suspend_n(bus_if.clock_suspend_n), .output_drive_enable_n(bus_if.output_drive_enable_n),
      .mem_dq_o(bus_if.mem_dq_o), .mem_dq_oe_n(bus_if.mem_dq_oe_n), .ctl_dq_oe_n(bus_if.ctl_dq_oe_n));
   // Output enable is the one bus input that neither end drives.
   assign bus_if.output_drive_enable_n = oe_n;

   // Free-running clock.
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Collect returned words; the ceiling is far above the under two hundred cycles the tests need.
   always @(posedge clk_i) begin
      cyc++;
      if (rvalid === 1'b1) rq.push_back(rdata);
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   // One command, held until the rising edge at which the FIFO has room.
   task send(input logic r, input logic a, input logic [7:0] ad, input logic [3:0] b, input logic [31:0] d);
      {vld, rd, adv, addr, ben_n, wd} = {1'b1, r, a, ad, b, d};
      while (rdy !== 1'b1) @(negedge clk_i);
      @(negedge clk_i);
   endtask : send

   // Write command; the model merges only enabled byte lanes into burst address pa.
   task wr(input logic a, input logic [7:0] pa, input logic [7:0] ad, input logic [3:0] b, input logic [31:0] d);
      for (int j = 0; j < 4; j++) if (!b[j]) mem[pa][8*j+:8] = d[8*j+:8];
      send(1'b0, a, ad, b, d);
   endtask : wr

   task wait_rq(input int n);
      int k;
      vld = 1'b0;
      k = 0;
      while (rq.size() < n && k < 300) begin
         @(negedge clk_i);
         k++;
      end
      check(rq.size(), n);
   endtask : wait_rq

   // Burst address k of a burst loaded at a.
   function logic [7:0] ba(input logic [7:0] a, input int k);
      return {a[7:2], ilv ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0]};
   endfunction : ba

   task t_mixed;
      for (int i = 0; i < 16; i++) wr(1'b0, 8'h10 + i[7:0], 8'h10 + i[7:0], 4'h0, 32'hA5000000 + i);
      for (int i = 0; i < 8; i++) begin
         send(1'b1, 1'b0, 8'h10 + i[7:0], 4'hF, 32'h0);
         wr(1'b0, 8'h30 + i[7:0], 8'h30 + i[7:0], 4'h0, 32'h5A000000 + i);
      end
      wait_rq(8);
      for (int i = 0; i < 8; i++) check(rq.pop_front(), mem[8'h10 + i]);
      $display("test mixed done");
   endtask : t_mixed

   task t_burst_rd(input logic il, input logic [7:0] s);
      ilv = il;
      send(1'b1, 1'b0, s, 4'hF, 32'h0);
      repeat (3) send(1'b1, 1'b1, s, 4'hF, 32'h0);
      wait_rq(4);
      for (int k = 0; k < 4; k++) check(rq.pop_front(), mem[ba(s, k)]);
      $display("test burst read done");
   endtask : t_burst_rd

   task t_burst_wr;
      for (int k = 0; k < 4; k++) wr(k != 0, ba(8'h32, k), 8'h32, k == 2 ? 4'hE : 4'h0, 32'hB0C0D0E0 + k);
      for (int k = 0; k < 4; k++) send(1'b1, 1'b0, 8'h30 + k[7:0], 4'hF, 32'h0);
      wait_rq(4);
      for (int k = 0; k < 4; k++) check(rq.pop_front(), mem[8'h30 + k]);
      $display("test burst write done");
   endtask : t_burst_wr

   // The bus is held suspended so the FIFO fills until it refuses.
   task t_suspend;
      int n;
      n = 0;
      susp = 1'b1;
      while (rdy === 1'b1 && n < 16) begin
         {vld, rd, adv, addr} = {1'b1, 1'b1, 1'b0, 8'h10 + n[7:0]};
         @(negedge clk_i);
         n++;
      end
      vld = 1'b0;
      check(n >= pssb_pkg::FIFO_DEPTH, 1'b1);
      repeat (4) @(negedge clk_i);
      // Single suspended edges while reads are in flight and words stand on the wire.
      susp = 1'b0;
      repeat (2) @(negedge clk_i);
      susp = 1'b1;
      @(negedge clk_i);
      susp = 1'b0;
      repeat (3) @(negedge clk_i);
      susp = 1'b1;
      @(negedge clk_i);
      susp = 1'b0;
      wait_rq(n);
      for (int i = 0; i < n; i++) check(rq.pop_front(), mem[8'h10 + i]);
      $display("test suspend done");
   endtask : t_suspend

   task t_oe;
      oe_n = 1'b1;
      send(1'b1, 1'b0, 8'h10, 4'hF, 32'h0);
      wait_rq(1);
      check(rq.pop_front(), 32'h0);
      oe_n = 1'b0;
      $display("test output enable done");
   endtask : t_oe

   // Reset, then the tests in turn.
   initial begin
      {nrst_i, vld, rd, adv, susp, ilv, oe_n, addr, ben_n, wd} = '0;
      repeat (4) @(negedge clk_i);
      nrst_i = 1'b1;
      t_mixed();
      t_burst_rd(1'b0, 8'h16);
      t_burst_rd(1'b1, 8'h1D);
      t_burst_wr();
      t_suspend();
      t_oe();
      report_and_stop();
   end
endmodule : test_pipelined_sync_sram_bus_ops
